// ===== cia_pkg.sv
package cia_pkg;
	// addressing modes
	typedef enum logic [3:0] {
		cia_mode_inherent = 4'h0,
		cia_mode_immediate = 4'h1,
		cia_mode_direct_short = 4'h2,
		cia_mode_direct_long = 4'h3,
		cia_mode_indexed_none = 4'h4,
		cia_mode_indexed_short = 4'h5,
		cia_mode_indexed_long = 4'h6,
		cia_mode_indirect_short = 4'h7,
		cia_mode_indirect_long = 4'h8
	} cia_mode_type;

	// inherent and accumulator operations
	typedef enum logic [3:0] {
		cia_op_none = 4'h0,
		cia_op_multiply = 4'h1,
		cia_op_logic_shift_right = 4'h2,
		cia_op_arith_shift_right = 4'h3,
		cia_op_rotate_left_carry = 4'h4,
		cia_op_rotate_right_carry = 4'h5,
		cia_op_interrupt_enable = 4'h6,
		cia_op_interrupt_disable = 4'h7,
		cia_op_trap = 4'h8,
		cia_op_wait_interrupt = 4'h9,
		cia_op_set_carry = 4'hA,
		cia_op_clear_carry = 4'hB,
		cia_op_stack_pointer_reset = 4'hC,
		cia_op_swap = 4'hD,
		cia_op_subtract_borrow = 4'hE,
		cia_op_jump_unsigned_le = 4'hF
	} cia_op_type;

	typedef enum logic [2:0] {
		cia_state_idle = 3'b000,
		cia_state_operand = 3'b001,
		cia_state_pointer = 3'b010,
		cia_state_execute = 3'b011,
		cia_state_wait = 3'b100
	} cia_state_type;

	typedef struct packed {
		logic valid;
		cia_mode_type mode;
		cia_op_type op;
		logic index_y;
	} cia_request_type;

	typedef struct packed {
		logic half_carry;
		logic negative;
		logic zero;
		logic carry;
		logic [1:0] interrupt_level_mask;
	} cia_flags_type;

	localparam logic [7:0] cia_accumulator_reset = 8'h00;
	localparam logic [7:0] cia_index_reset = 8'h00;
	localparam logic [15:0] cia_stack_pointer_max = 16'h17FF;
	localparam logic [1:0] cia_mask_level0 = 2'b10;
	localparam logic [1:0] cia_mask_level3 = 2'b11;
	localparam logic [1:0] cia_mask_reset = 2'b11;
	localparam logic [1:0] cia_bytes_zero = 2'h0;
	localparam logic [1:0] cia_bytes_one = 2'h1;
	localparam logic [1:0] cia_bytes_two = 2'h2;
endpackage : cia_pkg

// ===== cia_length.sv
`timescale 1ns/1ns
`default_nettype none
module cia_length (
	input wire cia_pkg::cia_mode_type mode,
	output logic [1:0] operand_bytes,
	output logic [1:0] pointer_bytes
);
	always_comb
	begin
		operand_bytes = cia_pkg::cia_bytes_zero;
		pointer_bytes = cia_pkg::cia_bytes_zero;
		unique case (mode)
			cia_pkg::cia_mode_inherent, cia_pkg::cia_mode_indexed_none:
				operand_bytes = cia_pkg::cia_bytes_zero;
			cia_pkg::cia_mode_immediate, cia_pkg::cia_mode_direct_short,
			cia_pkg::cia_mode_indexed_short:
				operand_bytes = cia_pkg::cia_bytes_one;
			cia_pkg::cia_mode_direct_long, cia_pkg::cia_mode_indexed_long:
				operand_bytes = cia_pkg::cia_bytes_two;
			cia_pkg::cia_mode_indirect_short:
			begin
				operand_bytes = cia_pkg::cia_bytes_one;
				pointer_bytes = cia_pkg::cia_bytes_one;
			end
			cia_pkg::cia_mode_indirect_long:
			begin
				operand_bytes = cia_pkg::cia_bytes_one;
				pointer_bytes = cia_pkg::cia_bytes_two;
			end
			default:
				operand_bytes = cia_pkg::cia_bytes_zero;
		endcase
	end
endmodule : cia_length
`default_nettype wire

// ===== cia_core.sv
`timescale 1ns/1ns
`default_nettype none
//Contract
// - no-operand instructions are one byte, decoded from the opcode alone
// - immediate instructions are two bytes; the operand byte is used directly
// - short direct takes one address byte, reaching 00 to FF
// - long direct takes a two-byte address, reaching the whole 64 Kbyte space
// - indexed address is unsigned sum of X or Y and an offset
// - indexed without offset uses no byte; address is the index alone
// - short indexed adds one offset byte to the index, up to 1FE
// - long indexed adds a two-byte offset, covering 64 Kbyte
// - short indirect reads pointer address, fetches one-byte pointer as address
// - long indirect reads pointer address, fetches two-byte pointer as address
// - multiply puts X times A in X high, A low; clears H and C
// - logical right shift inserts zero, LSB to carry, N cleared, Z updated
// - arithmetic right shift keeps bit 7, LSB to carry, updates N Z C
// - rotates pass through carry as nine bits, updating N Z C
// - interrupt enable sets the mask to binary 10, level 0
// - interrupt disable sets the mask to binary 11, level 3
// - trap leaves both mask bits set; wait leaves level 0 and stalls
// - set carry forces C to 1, clear carry to 0, others unchanged
// - swap exchanges nibbles and updates N and Z only
// - stack pointer reset loads the maximum allowed value
// - subtract with borrow: A minus M minus C into A, updates N Z C
// - unsigned less-or-equal jump taken when carry or zero is 1
module cia_core (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// decoded instruction request
	input wire cia_pkg::cia_request_type request,
	output logic request_ready,
	// program byte stream after the opcode
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	// data memory pointer read
	output logic pointer_read,
	output logic [15:0] pointer_address,
	input wire logic pointer_valid,
	input wire logic [7:0] pointer_data,
	// pending interrupt wakes the wait state
	input wire logic interrupt_pending,
	// results
	output logic done,
	output logic [15:0] effective_address,
	output logic [7:0] immediate_value,
	output logic jump_taken,
	output logic trap_entered,
	output logic waiting,
	output logic [7:0] accumulator,
	output logic [7:0] index_x,
	output logic [7:0] index_y,
	output logic [15:0] stack_pointer,
	output cia_pkg::cia_flags_type flags
);
	typedef struct packed {
		cia_pkg::cia_state_type state;
		cia_pkg::cia_request_type request;
		logic [1:0] operand_left;
		logic [1:0] pointer_left;
		logic [15:0] operand;
		logic [15:0] pointer;
		logic pointer_read;
		logic request_ready;
		logic byte_ready;
		logic done;
		logic [15:0] effective_address;
		logic [7:0] immediate_value;
		logic jump_taken;
		logic trap_entered;
		logic waiting;
		logic [7:0] accumulator;
		logic [7:0] index_x;
		logic [7:0] index_y;
		logic [15:0] stack_pointer;
		cia_pkg::cia_flags_type flags;
	} cia_core_state_type;

	cia_core_state_type state;
	cia_core_state_type next_state;
	logic [1:0] operand_bytes;
	logic [1:0] pointer_bytes;
	logic [15:0] product;
	logic [8:0] difference;
	logic [7:0] index_value;
	logic [7:0] result;

	// operand length comes from the mode field alone
	cia_length length_unit (
		.mode(request.mode),
		.operand_bytes(operand_bytes),
		.pointer_bytes(pointer_bytes)
	);

	always_comb
	begin
		next_state = state;
		next_state.done = 1'b0;
		next_state.trap_entered = 1'b0;
		next_state.jump_taken = 1'b0;
		product = 16'(state.index_x) * 16'(state.accumulator);
		difference = 9'({1'b0, state.accumulator}) - 9'(state.operand[7:0])
			- 9'(state.flags.carry);
		index_value = state.request.index_y ? state.index_y : state.index_x;
		result = 8'h00;
		unique case (state.state)
			cia_pkg::cia_state_idle:
			begin
				if (request.valid)
				begin
					next_state.request = request;
					next_state.operand = 16'h0000;
					next_state.pointer = 16'h0000;
					next_state.operand_left = operand_bytes;
					next_state.pointer_left = pointer_bytes;
					next_state.request_ready = 1'b0;
					next_state.byte_ready = operand_bytes != cia_pkg::cia_bytes_zero;
					next_state.state = operand_bytes != cia_pkg::cia_bytes_zero
						? cia_pkg::cia_state_operand : cia_pkg::cia_state_execute;
				end
			end
			cia_pkg::cia_state_operand:
			begin
				// multi-byte fields arrive high byte first
				if (byte_valid)
				begin
					next_state.operand = {state.operand[7:0], byte_data};
					next_state.operand_left = state.operand_left - 2'h1;
					if (state.operand_left == cia_pkg::cia_bytes_one)
					begin
						next_state.byte_ready = 1'b0;
						if (state.pointer_left != cia_pkg::cia_bytes_zero)
						begin
							next_state.state = cia_pkg::cia_state_pointer;
							next_state.pointer_read = 1'b1;
							next_state.pointer = {8'h00, byte_data};
						end
						else
							next_state.state = cia_pkg::cia_state_execute;
					end
				end
			end
			cia_pkg::cia_state_pointer:
			begin
				// pointer bytes come from the short pointer address
				if (pointer_valid)
				begin
					next_state.operand = {state.operand[7:0], pointer_data};
					next_state.pointer_left = state.pointer_left - 2'h1;
					next_state.pointer = state.pointer + 16'h0001;
					if (state.pointer_left == cia_pkg::cia_bytes_one)
					begin
						next_state.pointer_read = 1'b0;
						next_state.state = cia_pkg::cia_state_execute;
					end
				end
			end
			cia_pkg::cia_state_execute:
			begin
				next_state.done = 1'b1;
				next_state.request_ready = 1'b1;
				next_state.state = cia_pkg::cia_state_idle;
				unique case (state.request.mode)
					cia_pkg::cia_mode_immediate:
						next_state.immediate_value = state.operand[7:0];
					cia_pkg::cia_mode_direct_short:
						next_state.effective_address = {8'h00, state.operand[7:0]};
					cia_pkg::cia_mode_indexed_none:
						next_state.effective_address = {8'h00, index_value};
					cia_pkg::cia_mode_indexed_short:
						next_state.effective_address = 16'(state.operand[7:0]) + 16'(index_value);
					// long offset wraps within 64 Kbyte
					cia_pkg::cia_mode_indexed_long:
						next_state.effective_address = state.operand + 16'(index_value);
					cia_pkg::cia_mode_indirect_short:
						next_state.effective_address = {8'h00, state.operand[7:0]};
					default:
						next_state.effective_address = state.operand;
				endcase
				unique case (state.request.op)
					// product split across X and A
					cia_pkg::cia_op_multiply:
					begin
						next_state.index_x = product[15:8];
						next_state.accumulator = product[7:0];
						next_state.flags.half_carry = 1'b0;
						next_state.flags.carry = 1'b0;
					end
					cia_pkg::cia_op_logic_shift_right:
					begin
						result = {1'b0, state.accumulator[7:1]};
						next_state.accumulator = result;
						next_state.flags.carry = state.accumulator[0];
						next_state.flags.negative = 1'b0;
						next_state.flags.zero = result == 8'h00;
					end
					cia_pkg::cia_op_arith_shift_right:
					begin
						result = {state.accumulator[7], state.accumulator[7:1]};
						next_state.accumulator = result;
						next_state.flags.carry = state.accumulator[0];
						next_state.flags.negative = result[7];
						next_state.flags.zero = result == 8'h00;
					end
					cia_pkg::cia_op_rotate_left_carry:
					begin
						result = {state.accumulator[6:0], state.flags.carry};
						next_state.accumulator = result;
						next_state.flags.carry = state.accumulator[7];
						next_state.flags.negative = result[7];
						next_state.flags.zero = result == 8'h00;
					end
					cia_pkg::cia_op_rotate_right_carry:
					begin
						result = {state.flags.carry, state.accumulator[7:1]};
						next_state.accumulator = result;
						next_state.flags.carry = state.accumulator[0];
						next_state.flags.negative = result[7];
						next_state.flags.zero = result == 8'h00;
					end
					cia_pkg::cia_op_interrupt_enable:
						next_state.flags.interrupt_level_mask = cia_pkg::cia_mask_level0;
					cia_pkg::cia_op_interrupt_disable:
						next_state.flags.interrupt_level_mask = cia_pkg::cia_mask_level3;
					cia_pkg::cia_op_trap:
					begin
						next_state.flags.interrupt_level_mask = cia_pkg::cia_mask_level3;
						next_state.trap_entered = 1'b1;
					end
					// wait opens level 0 and stalls
					cia_pkg::cia_op_wait_interrupt:
					begin
						next_state.flags.interrupt_level_mask = cia_pkg::cia_mask_level0;
						next_state.done = 1'b0;
						next_state.request_ready = 1'b0;
						next_state.waiting = 1'b1;
						next_state.state = cia_pkg::cia_state_wait;
					end
					cia_pkg::cia_op_set_carry:
						next_state.flags.carry = 1'b1;
					cia_pkg::cia_op_clear_carry:
						next_state.flags.carry = 1'b0;
					cia_pkg::cia_op_stack_pointer_reset:
						next_state.stack_pointer = cia_pkg::cia_stack_pointer_max;
					cia_pkg::cia_op_swap:
					begin
						result = {state.accumulator[3:0], state.accumulator[7:4]};
						next_state.accumulator = result;
						next_state.flags.negative = result[7];
						next_state.flags.zero = result == 8'h00;
					end
					cia_pkg::cia_op_subtract_borrow:
					begin
						next_state.accumulator = difference[7:0];
						next_state.flags.carry = difference[8];
						next_state.flags.negative = difference[7];
						next_state.flags.zero = difference[7:0] == 8'h00;
					end
					cia_pkg::cia_op_jump_unsigned_le:
						next_state.jump_taken = state.flags.carry | state.flags.zero;
					cia_pkg::cia_op_none:
						next_state.done = 1'b1;
				endcase
			end
			cia_pkg::cia_state_wait:
			begin
				// a masked request still wakes the core; dispatch is elsewhere
				if (interrupt_pending)
				begin
					next_state.waiting = 1'b0;
					next_state.done = 1'b1;
					next_state.request_ready = 1'b1;
					next_state.state = cia_pkg::cia_state_idle;
				end
			end
			default:
				next_state.state = cia_pkg::cia_state_idle;
		endcase
		// a request in flight drops ready from the cycle after it is taken
		if (state.state == cia_pkg::cia_state_idle && request.valid)
			next_state.request_ready = 1'b0;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= '0;
			state.state <= cia_pkg::cia_state_idle;
			state.request_ready <= 1'b1;
			state.accumulator <= cia_pkg::cia_accumulator_reset;
			state.index_x <= cia_pkg::cia_index_reset;
			state.index_y <= cia_pkg::cia_index_reset;
			state.stack_pointer <= cia_pkg::cia_stack_pointer_max;
			state.flags.interrupt_level_mask <= cia_pkg::cia_mask_reset;
		end
		else
			state <= next_state;
	end

	assign request_ready = state.request_ready;
	assign byte_ready = state.byte_ready;
	assign pointer_read = state.pointer_read;
	assign pointer_address = state.pointer;
	assign done = state.done;
	assign effective_address = state.effective_address;
	assign immediate_value = state.immediate_value;
	assign jump_taken = state.jump_taken;
	assign trap_entered = state.trap_entered;
	assign waiting = state.waiting;
	assign accumulator = state.accumulator;
	assign index_x = state.index_x;
	assign index_y = state.index_y;
	assign stack_pointer = state.stack_pointer;
	assign flags = state.flags;
endmodule : cia_core
`default_nettype wire

// ===== cia_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module cia_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// request side
	input wire cia_pkg::cia_request_type request,
	input wire logic request_ready,
	input wire logic byte_ready,
	// results
	input wire logic done,
	input wire logic [15:0] effective_address,
	input wire logic jump_taken,
	input wire logic trap_entered,
	input wire logic [7:0] accumulator,
	input wire logic [15:0] stack_pointer,
	input wire cia_pkg::cia_flags_type flags
);
	cia_pkg::cia_mode_type taken_mode;
	cia_pkg::cia_op_type taken_op;
	logic take;
	assign take = request.valid && request_ready;
	// results only show at done, so keep the instruction in flight
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			taken_mode <= cia_pkg::cia_mode_inherent;
			taken_op <= cia_pkg::cia_op_none;
		end
		else if (take)
		begin
			taken_mode <= request.mode;
			taken_op <= request.op;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	inherent_len_a: assert property (take && request.mode == cia_pkg::cia_mode_inherent &&
		request.op != cia_pkg::cia_op_wait_interrupt |=> !byte_ready ##1 done)
		else $error("inherent op took operand bytes or was late");
	imm_byte_a: assert property (
		take && request.mode == cia_pkg::cia_mode_immediate |=> byte_ready)
		else $error("immediate op did not ask for its operand");
	idx_none_a: assert property (take && request.mode == cia_pkg::cia_mode_indexed_none |=>
		!byte_ready ##1 done && effective_address[15:8] == 8'h00)
		else $error("indexed without offset used a byte or left 00 to FF");
	ind_short_a: assert property (
		done && taken_mode == cia_pkg::cia_mode_indirect_short |-> effective_address[15:8] == 8'h00)
		else $error("short indirect address above FF");
	mul_flags_a: assert property (
		done && taken_op == cia_pkg::cia_op_multiply |-> !flags.carry && !flags.half_carry)
		else $error("multiply left carry or half carry set");
	srl_flags_a: assert property (done && taken_op == cia_pkg::cia_op_logic_shift_right |->
		!flags.negative && !accumulator[7] && flags.zero == (accumulator == 8'h00))
		else $error("logical shift flags wrong");
	mask_on_a: assert property (
		done && taken_op == cia_pkg::cia_op_interrupt_enable |-> flags.interrupt_level_mask == 2'h2)
		else $error("interrupt enable mask wrong");
	trap_mask_a: assert property (
		trap_entered |-> done && flags.interrupt_level_mask == 2'h3)
		else $error("trap without done or full mask");
	sp_max_a: assert property (
		done && taken_op == cia_pkg::cia_op_stack_pointer_reset |-> stack_pointer == 16'h17FF)
		else $error("stack pointer not at maximum");
	jump_le_a: assert property (
		done |-> jump_taken == (taken_op == cia_pkg::cia_op_jump_unsigned_le
		&& (flags.carry || flags.zero)))
		else $error("unsigned jump decision wrong");
endmodule : cia_monitor
bind cia_core cia_monitor mon_u (.clock(clock), .rst(rst), .request(request),
	.request_ready(request_ready), .byte_ready(byte_ready), .done(done),
	.effective_address(effective_address), .jump_taken(jump_taken), .trap_entered(trap_entered),
	.accumulator(accumulator), .stack_pointer(stack_pointer), .flags(flags));
`default_nettype wire

// ===== cia_memory_model.sv
`timescale 1ns/1ns
`default_nettype none
module cia_memory_model (
	// clock, reset and pacing
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] delay,
	input wire logic request_ready,
	// program bytes after the opcode
	input wire logic [15:0] operand,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data,
	// data memory holds address xor 5A
	input wire logic pointer_read,
	input wire logic [15:0] pointer_address,
	output logic pointer_valid,
	output logic [7:0] pointer_data
);
	logic [1:0] wait_count;
	logic second;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			byte_valid <= 1'h0;
			pointer_valid <= 1'h0;
			byte_data <= 8'h00;
			pointer_data <= 8'h00;
			wait_count <= 2'h0;
			second <= 1'h0;
		end
		else
		begin
			second <= second && !request_ready;
			// released lines show the inverse so a stale byte is never taken
			if (byte_valid && byte_ready)
			begin
				byte_valid <= 1'h0;
				byte_data <= ~byte_data;
				wait_count <= 2'h0;
				second <= 1'h1;
			end
			else if (pointer_valid && pointer_read)
			begin
				pointer_valid <= 1'h0;
				pointer_data <= ~pointer_data;
				wait_count <= 2'h0;
			end
			else if ((byte_ready || pointer_read) && wait_count != delay)
				wait_count <= wait_count + 2'h1;
			else if (byte_ready && !byte_valid)
			begin
				byte_valid <= 1'h1;
				byte_data <= second ? operand[7:0] : operand[15:8];
			end
			else if (pointer_read && !pointer_valid)
			begin
				pointer_valid <= 1'h1;
				pointer_data <= pointer_address[7:0] ^ 8'h5A;
			end
		end
	end
endmodule : cia_memory_model
`default_nettype wire

// ===== tb_cpu_instruction_addressing.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_instruction_addressing;
	logic clock, rst, interrupt_pending;
	cia_pkg::cia_request_type request;
	logic [1:0] delay;
	logic [15:0] operand;
	wire logic request_ready, byte_valid, byte_ready, pointer_read, pointer_valid, done;
	wire logic jump_taken, trap_entered, waiting;
	wire logic [7:0] byte_data, pointer_data, immediate_value, accumulator, index_x, index_y;
	wire logic [15:0] pointer_address, effective_address, stack_pointer;
	wire cia_pkg::cia_flags_type flags;
	int errors, checks;
	logic [7:0] a, x, y;
	logic [15:0] sp;
	cia_pkg::cia_flags_type f;
	cia_core dut_u (.clock(clock), .rst(rst), .request(request), .request_ready(request_ready),
		.byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
		.pointer_read(pointer_read), .pointer_address(pointer_address),
		.pointer_valid(pointer_valid), .pointer_data(pointer_data),
		.interrupt_pending(interrupt_pending), .done(done), .effective_address(effective_address),
		.immediate_value(immediate_value), .jump_taken(jump_taken), .trap_entered(trap_entered),
		.waiting(waiting), .accumulator(accumulator), .index_x(index_x), .index_y(index_y),
		.stack_pointer(stack_pointer), .flags(flags));
	cia_memory_model mem_u (.clock(clock), .rst(rst), .delay(delay), .request_ready(request_ready),
		.operand(operand), .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data),
		.pointer_read(pointer_read), .pointer_address(pointer_address),
		.pointer_valid(pointer_valid), .pointer_data(pointer_data));
	initial
	begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic summarize;
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	task automatic do_reset;
		@(posedge clock);
		rst <= 1'h1;
		repeat (3) @(posedge clock);
		rst <= 1'h0;
		{a, x, y} = 24'h000000;
		sp = cia_pkg::cia_stack_pointer_max;
		f = '{1'h0, 1'h0, 1'h0, 1'h0, 2'h3};
		#1;
		chk("ready", 16'h0001, 16'(request_ready));
		chk("flags", 16'(f), 16'(flags));
		chk("sp", sp, stack_pointer);
	endtask : do_reset
	task automatic run(input cia_pkg::cia_mode_type m, input cia_pkg::cia_op_type o, input logic yy);
		int n;
		logic seen, jt;
		logic [7:0] b, idx;
		logic [8:0] r;
		logic [15:0] ea;
		@(posedge clock);
		operand <= 16'($urandom);
		delay <= 2'($urandom);
		interrupt_pending <= 1'h0;
		request <= '{1'h1, m, o, yy};
		@(posedge clock);
		request.valid <= 1'h0;
		seen = 1'h0;
		for (n = 0; n < 40 && !seen; n++)
		begin
			@(posedge clock);
			interrupt_pending <= (o == cia_pkg::cia_op_wait_interrupt) && (n > 3);
			#1;
			if (o == cia_pkg::cia_op_wait_interrupt && n == 3)
				chk("waiting", 16'h0001, 16'(waiting));
			seen = (done === 1'h1);
		end
		if (!seen)
		begin
			chk("done", 16'h0001, 16'h0000);
			summarize();
		end
		b = operand[15:8];
		idx = yy ? y : x;
		jt = (o == cia_pkg::cia_op_jump_unsigned_le) && (f.carry || f.zero);
		case (m)
			cia_pkg::cia_mode_direct_short: ea = {8'h00, b};
			cia_pkg::cia_mode_direct_long: ea = operand;
			cia_pkg::cia_mode_indexed_none: ea = {8'h00, idx};
			cia_pkg::cia_mode_indexed_short: ea = 16'(idx) + 16'(b);
			cia_pkg::cia_mode_indexed_long: ea = 16'(idx) + operand;
			cia_pkg::cia_mode_indirect_short: ea = {8'h00, b ^ 8'h5A};
			default: ea = {b ^ 8'h5A, (b + 8'h01) ^ 8'h5A};
		endcase
		case (o)
			cia_pkg::cia_op_multiply: {x, a, f.half_carry, f.carry} = {16'(x) * 16'(a), 2'h0};
			cia_pkg::cia_op_logic_shift_right: {a, f.carry} = {1'h0, a};
			cia_pkg::cia_op_arith_shift_right: {a, f.carry} = {a[7], a};
			cia_pkg::cia_op_rotate_left_carry: {f.carry, a} = {a, f.carry};
			cia_pkg::cia_op_rotate_right_carry: {a, f.carry} = {f.carry, a};
			cia_pkg::cia_op_interrupt_enable: f.interrupt_level_mask = 2'h2;
			cia_pkg::cia_op_wait_interrupt: f.interrupt_level_mask = 2'h2;
			cia_pkg::cia_op_interrupt_disable: f.interrupt_level_mask = 2'h3;
			cia_pkg::cia_op_trap: f.interrupt_level_mask = 2'h3;
			cia_pkg::cia_op_set_carry: f.carry = 1'h1;
			cia_pkg::cia_op_clear_carry: f.carry = 1'h0;
			cia_pkg::cia_op_stack_pointer_reset: sp = cia_pkg::cia_stack_pointer_max;
			cia_pkg::cia_op_swap: a = {a[3:0], a[7:4]};
			cia_pkg::cia_op_subtract_borrow:
			begin
				r = {1'h0, a} - 9'(b) - 9'(f.carry);
				{f.carry, a} = r;
			end
			default: ;
		endcase
		if (4'(o) inside {[4'h2:4'h5], 4'hD, 4'hE})
			{f.negative, f.zero} = {a[7], a == 8'h00};
		chk("acc", 16'(a), 16'(accumulator));
		chk("index", {x, y}, {index_x, index_y});
		chk("flags", 16'(f), 16'(flags));
		chk("sp", sp, stack_pointer);
		chk("jump", 16'(jt), 16'(jump_taken));
		chk("trap", 16'(o == cia_pkg::cia_op_trap), 16'(trap_entered));
		chk("waiting", 16'h0000, 16'(waiting));
		if (m > cia_pkg::cia_mode_immediate)
			chk("address", ea, effective_address);
		if (m == cia_pkg::cia_mode_immediate)
			chk("immediate", 16'(b), 16'(immediate_value));
	endtask : run
	initial
	begin
		int i;
		cia_pkg::cia_op_type o;
		cia_pkg::cia_mode_type m;
		errors = 0;
		checks = 0;
		rst = 1'h1;
		request = '0;
		operand = 16'h0000;
		delay = 2'h0;
		interrupt_pending = 1'h0;
		void'($urandom(55));
		do_reset();
		// every op first, then every addressing mode, then a random mix
		for (i = 0; i < 90; i++)
		begin
			if (i == 60)
				do_reset();
			o = cia_pkg::cia_op_type'(4'(i < 16 ? i : i < 25 ? 0 : $urandom));
			m = cia_pkg::cia_mode_type'(4'(i < 25 ? i - 16 : $urandom % 9));
			if (o != cia_pkg::cia_op_none)
				m = (o == cia_pkg::cia_op_subtract_borrow) ? cia_pkg::cia_mode_immediate
					: cia_pkg::cia_mode_inherent;
			run(m, o, 1'($urandom));
		end
		summarize();
	end
endmodule : tb_cpu_instruction_addressing
`default_nettype wire
